// File: bench/cfm_osc_model.sv
// Behavioural primary oscillator that can run, never start, or stop on command
`timescale 1ns/1ps
`default_nettype none
module cfm_osc_model #(
  parameter int unsigned HALF_NS = 30
)(
  input  wire logic en_i,
  input  wire logic alive_i,
  output var  logic clk_o
);
  initial clk_o = 1'b0;

  // A dead or disabled oscillator holds its pin still, which is what the monitor must catch
  always
  begin
    #(HALF_NS);
    if (en_i && alive_i)
      clk_o = ~clk_o;
  end
endmodule // cfm_osc_model
`default_nettype wire

// File: bench/tb_cfm_ctrl.sv
// Self-checking testbench for the clock fail monitor controller
`timescale 1ns/1ps
`default_nettype none
module tb_cfm_ctrl;
  import cfm_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, wake, irq_req, alive;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, rd;
  logic [1:0]  mode, clk_sel;
  logic        prim_clk, prim_en, cpu_run, run_flag, irq, ack;
  int          err_count, n_tests;

  cfm_ctrl #(.PLL_CYCLES(50), .START_EDGES(8), .SAMPLE_CYCLES(16)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .prim_clk_i(prim_clk), .cfg_osc_mode_i(mode), .wake_i(wake), .irq_req_i(irq_req),
    .clk_sel_o(clk_sel), .primary_en_o(prim_en), .cpu_run_o(cpu_run), .run_flag_o(run_flag),
    .irq_o(irq)
  );

  cfm_osc_model u_osc (.en_i(prim_en), .alive_i(alive), .clk_o(prim_clk));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic timeout(input string name);
    err_count++;
    $display("BAD %s expected done seen timeout", name);
    report_and_stop();
  endtask

  // One classic cycle: held until ack is sampled high, then released for at least a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    n = 1;
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1)
      timeout("bus ack");
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(name, rd & m, exp);
  endtask

  task automatic pm(input logic [31:0] d);
    wb(1'b1, OFF_PM_CMD, d);
    #1;
  endtask

  task automatic poll_fail;
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[ST_FAIL_BIT] !== 1'b1 && n < 60)
    begin
      wb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    if (rd[ST_FAIL_BIT] !== 1'b1)
      timeout("fail flag");
  endtask

  task automatic do_reset(input logic [1:0] m, input logic al);
    @(posedge clk_i);
    mode  <= m;
    alive <= al;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic t_regs;
    do_reset(2'h1, 1'b1);
    chk("clk_sel after reset", clk_sel, 32'h2);
    chk("run flag after reset", run_flag, 32'h0);
    chk("primary enable", prim_en, 32'h1);
    chk("irq after reset", irq, 32'h0);
    rd_chk("osc control reset", OFF_OSC_CTRL, 32'hF, 32'h0);
    wb(1'b1, OFF_OSC_CTRL, 32'hF);
    rd_chk("osc control read only", OFF_OSC_CTRL, 32'hB, 32'h0);
    rd_chk("status reset", OFF_STATUS, 32'h3, 32'h0);
    wb(1'b1, OFF_MASK, 32'h3);
    rd_chk("mask rw", OFF_MASK, 32'h3, 32'h3);
    wb(1'b1, OFF_MASK, 32'h0);
    rd_chk("unmapped read", 8'h10, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_crystal;
    int n;
    n = 0;
    while (run_flag !== 1'b1 && n < 400)
    begin
      if (clk_sel !== 2'h2)
        chk("rc while starting", clk_sel, 32'h2);
      @(posedge clk_i);
      n++;
    end
    if (run_flag !== 1'b1)
      timeout("primary ready");
    #1;
    chk("switched to primary", clk_sel, 32'h0);
    rd_chk("running flag bit", OFF_OSC_CTRL, 32'h8, 32'h8);
    rd_chk("ready event", OFF_STATUS, 32'h2, 32'h2);
    alive <= 1'b0;
    poll_fail();
    #1;
    chk("fallback to rc", clk_sel, 32'h2);
    alive <= 1'b1;
    repeat (100) @(posedge clk_i);
    #1;
    chk("fail persists", clk_sel, 32'h2);
    rd_chk("fail state", OFF_PM_CMD, 32'h1F, 32'h4);
    pm(32'h01);
    chk("pm entry ends fail", clk_sel, 32'h0);
    rd_chk("pm state", OFF_PM_CMD, 32'h1F, 32'h8);
  endtask

  task automatic t_idle_irq;
    wb(1'b1, OFF_STATUS, 32'h3);
    wb(1'b1, OFF_MASK, 32'h1);
    pm(32'h09);
    chk("idle halts cpu", cpu_run, 32'h0);
    alive <= 1'b0;
    poll_fail();
    repeat (2) @(posedge clk_i);
    #1;
    chk("rc after pm fail", clk_sel, 32'h2);
    chk("fail irq", irq, 32'h1);
    chk("cpu resumes", cpu_run, 32'h1);
    alive <= 1'b1;
    repeat (100) @(posedge clk_i);
    #1;
    chk("no return to primary", clk_sel, 32'h2);
    wb(1'b1, OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq cleared", irq, 32'h0);
  endtask

  task automatic t_idle_noirq;
    wb(1'b1, OFF_MASK, 32'h0);
    wb(1'b1, OFF_STATUS, 32'h3);
    pm(32'h09);
    chk("idle on primary", clk_sel, 32'h0);
    alive <= 1'b0;
    poll_fail();
    repeat (4) @(posedge clk_i);
    #1;
    chk("masked fail no irq", irq, 32'h0);
    chk("still idle", cpu_run, 32'h0);
    @(posedge clk_i);
    irq_req <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq ends idle", cpu_run, 32'h1);
    chk("runs on rc", clk_sel, 32'h2);
    @(posedge clk_i);
    irq_req <= 1'b0;
  endtask

  task automatic t_never;
    int n;
    do_reset(2'h2, 1'b0);
    wb(1'b1, OFF_MASK, 32'h1);
    n = 0;
    while (run_flag !== 1'b1 && n < 500)
    begin
      @(posedge clk_i);
      n++;
    end
    #1;
    chk("never running", run_flag, 32'h0);
    chk("stays on rc", clk_sel, 32'h2);
    rd_chk("control unchanged", OFF_OSC_CTRL, 32'hB, 32'h0);
    rd_chk("no fail flag", OFF_STATUS, 32'h1, 32'h0);
    chk("no fail irq", irq, 32'h0);
    pm(32'h03);
    chk("primary disabled", prim_en, 32'h0);
    chk("secondary selected", clk_sel, 32'h1);
    rd_chk("control source", OFF_OSC_CTRL, 32'h3, 32'h1);
  endtask

  task automatic t_ext;
    do_reset(2'h0, 1'b1);
    repeat (30) @(posedge clk_i);
    alive <= 1'b0;
    poll_fail();
    #1;
    chk("ext fail on rc", clk_sel, 32'h2);
  endtask

  // Internal RC strap with a dead pin, then a sleep and a wake-up through the pin synchroniser
  task automatic t_sleep;
    do_reset(2'h3, 1'b0);
    repeat (40) @(posedge clk_i);
    #1;
    chk("rc strap running", run_flag, 32'h1);
    chk("rc strap on primary", clk_sel, 32'h0);
    rd_chk("rc strap no fail", OFF_STATUS, 32'h1, 32'h0);
    pm(32'h11);
    chk("sleep halts cpu", cpu_run, 32'h0);
    chk("sleep stops primary", prim_en, 32'h0);
    rd_chk("sleep state", OFF_PM_CMD, 32'h1F, 32'h10);
    rd_chk("sleep keeps control", OFF_OSC_CTRL, 32'h3, 32'h0);
    @(posedge clk_i);
    wake <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    chk("wake restarts cpu", cpu_run, 32'h1);
    chk("wake primary enable", prim_en, 32'h1);
    chk("wake back on primary", clk_sel, 32'h0);
    chk("wake running flag", run_flag, 32'h1);
    rd_chk("wake state", OFF_PM_CMD, 32'h1F, 32'h2);
    @(posedge clk_i);
    wake <= 1'b0;
  endtask

  initial
  begin
    err_count = 0;
    n_tests   = 0;
    rst_i     = 1'b1;
    cyc       = 1'b0;
    stb       = 1'b0;
    we        = 1'b0;
    adr       = 8'h00;
    dat       = 32'h0;
    mode      = 2'h1;
    wake      = 1'b0;
    irq_req   = 1'b0;
    alive     = 1'b1;
    t_regs();
    t_crystal();
    t_idle_irq();
    t_idle_noirq();
    t_never();
    t_ext();
    t_sleep();
    report_and_stop();
  end
endmodule // tb_cfm_ctrl
`default_nettype wire

// File: design/cfm_ctrl.sv
// Fail-safe clock monitor and clock source fallback controller
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cfm_ctrl
  import cfm_pkg::*;
#(
  parameter int unsigned PLL_CYCLES    = PLL_LOCK_CYC,
  parameter int unsigned START_EDGES   = OSC_START_CYC,
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        prim_clk_i,
  input  wire logic [1:0]  cfg_osc_mode_i,
  input  wire logic        wake_i,
  input  wire logic        irq_req_i,
  output logic      [1:0]  clk_sel_o,
  output logic             primary_en_o,
  output logic             cpu_run_o,
  output logic             run_flag_o,
  output logic             irq_o
);
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  cfm_mon_if mon ();

  cfm_fail_det #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_det (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .prim_clk_i (prim_clk_i),
    .mon        (mon.det)
  );

  cfm_start_tmr #(
    .START_EDGES (START_EDGES),
    .PLL_CYCLES  (PLL_CYCLES)
  ) u_tmr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mon   (mon.tmr)
  );

  // Pin synchronisers; the strap is taken once after reset release
  logic       wake1_q;
  logic       wake2_q;
  logic [1:0] cfg1_q;
  logic [1:0] cfg2_q;
  always_ff @(posedge clk_i)
  begin
    wake1_q <= wake_i;
    wake2_q <= wake1_q;
    cfg1_q  <= cfg_osc_mode_i;
    cfg2_q  <= cfg1_q;
  end

  cfm_state_t state_q;
  cfm_state_t state_d;
  cfm_cfg_t   cfg_q;
  cfm_src_t   osc_src_q;
  cfm_src_t   osc_src_d;
  cfm_src_t   clk_sel_q;
  cfm_src_t   clk_sel_d;
  logic       boot_q;
  logic       pm_fail_q;
  logic       pm_fail_d;
  logic       idle_q;
  logic       idle_d;
  logic       run_flag_q;
  logic       run_flag_d;
  logic       primary_en_q;
  logic       primary_en_d;
  logic       cpu_run_q;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic       irq_q;
  // Remembers a power-managed entry since reset; only then may the control register source field leave its reset value
  logic       pm_seen_q;
  logic       ack_q;
  logic [31:0] dat_q;

  // Bus decode
  wire logic     acc      = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic     wr0      = acc && wb_we_i && wb_sel_i[0];
  wire logic     pm_go    = wr0 && hit(wb_adr_i, OFF_PM_CMD) && wb_dat_i[PM_GO_BIT];
  wire cfm_src_t pm_src   = cfm_src_t'(wb_dat_i[PM_SRC_LSB +: 2]);
  wire cfm_pm_t  pm_mode  = cfm_pm_t'(wb_dat_i[PM_MODE_LSB +: 2]);
  wire logic     pm_enter = pm_go && (state_q != ST_SLEEP);
  wire logic     to_pm    = pm_enter && (pm_mode != PM_SLEEP);
  wire logic     wake     = (state_q == ST_SLEEP) && wake2_q;
  wire logic [1:0] w1c    = (wr0 && hit(wb_adr_i, OFF_STATUS)) ? wb_dat_i[1:0] : 2'h0;

  // Crystal modes keep the monitor off while starting, so no false failure
  assign mon.need_start = (cfg_q == CFG_SPEED_XTAL) || (cfg_q == CFG_XTAL_PLL);
  assign mon.need_pll   = (cfg_q == CFG_XTAL_PLL);
  assign mon.tmr_start  = boot_q || wake;
  // The pin is only watched when it really carries the primary clock
  wire logic pin_used = (cfg_q != CFG_INT_RC);
  assign mon.mon_en = ((state_q == ST_START) && (cfg_q == CFG_EXT_CLOCK))
                   || ((state_q == ST_PRIM) && pin_used)
                   || ((state_q == ST_PM) && (osc_src_q == SRC_PRIMARY) && !pm_fail_q && pin_used);

  wire logic fail_ev  = mon.fail && ((state_q == ST_START) || (state_q == ST_PRIM) || (state_q == ST_PM));
  wire logic ready_ev = (state_q == ST_START) && (state_d == ST_PRIM);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_START:
        if (mon.fail)
          state_d = ST_FAIL;
        else if (mon.ready)
          state_d = ST_PRIM;
      ST_PRIM:
        if (mon.fail)
          state_d = ST_FAIL;
      ST_FAIL:
        state_d = ST_FAIL;
      ST_PM:
        state_d = ST_PM;
      ST_SLEEP:
        if (wake2_q)
          state_d = ST_START;
      default:
        state_d = ST_START;
    endcase
    if (pm_enter)
      state_d = (pm_mode == PM_SLEEP) ? ST_SLEEP : ST_PM;
  end

  // The control register source field changes only on power-managed entry
  assign osc_src_d = to_pm ? pm_src : osc_src_q;
  // A failure in power-managed mode latches fallback; only a new run or idle entry, or a wake from sleep, clears it
  assign pm_fail_d = (to_pm || wake) ? 1'b0 : (pm_fail_q || ((state_q == ST_PM) && mon.fail));
  assign idle_d    = pm_enter ? (pm_mode == PM_IDLE)
                   : ((irq_req_i || irq_q) ? 1'b0 : idle_q);

  always_comb
  begin
    clk_sel_d    = SRC_INT_RC;
    primary_en_d = 1'b1;
    case (state_d)
      ST_START:
        clk_sel_d = SRC_INT_RC;
      ST_PRIM:
        clk_sel_d = SRC_PRIMARY;
      ST_FAIL:
        clk_sel_d = SRC_INT_RC;
      ST_PM:
      begin
        clk_sel_d    = pm_fail_d ? SRC_INT_RC : osc_src_d;
        primary_en_d = (osc_src_d == SRC_PRIMARY);
      end
      ST_SLEEP:
        primary_en_d = 1'b0;
      default:
        clk_sel_d = SRC_INT_RC;
    endcase
  end

  assign run_flag_d = (state_d == ST_PRIM)
                   || ((state_d == ST_PM) && (osc_src_d == SRC_PRIMARY) && !pm_fail_d);
  // Set wins over a write-one-to-clear in the same cycle
  assign status_d = (status_q & ~w1c) | ({1'b0, fail_ev} << ST_FAIL_BIT)
                  | ({1'b0, ready_ev} << ST_READY_BIT);
  assign mask_d   = (wr0 && hit(wb_adr_i, OFF_MASK)) ? wb_dat_i[1:0] : mask_q;

  wire logic [31:0] rd_osc = (32'(run_flag_q) << RUN_FLAG_BIT) | (32'(osc_src_q) << SRC_LSB);
  wire logic [31:0] rd_dat = hit(wb_adr_i, OFF_OSC_CTRL) ? rd_osc
                           : hit(wb_adr_i, OFF_PM_CMD)   ? 32'(state_q)
                           : hit(wb_adr_i, OFF_STATUS)   ? 32'(status_q)
                           : hit(wb_adr_i, OFF_MASK)     ? 32'(mask_q)
                           : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      boot_q <= 1'b1;
      cfg_q  <= CFG_INT_RC;
    end
    else
    begin
      boot_q <= 1'b0;
      if (boot_q)
        cfg_q <= cfm_cfg_t'(cfg2_q);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q      <= ST_START;
      osc_src_q    <= SRC_PRIMARY;
      clk_sel_q    <= SRC_INT_RC;
      pm_fail_q    <= 1'b0;
      idle_q       <= 1'b0;
      run_flag_q   <= 1'b0;
      primary_en_q <= 1'b1;
      cpu_run_q    <= 1'b1;
      status_q     <= STATUS_RST;
      mask_q       <= MASK_RST;
      irq_q        <= 1'b0;
      pm_seen_q    <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      osc_src_q    <= osc_src_d;
      clk_sel_q    <= clk_sel_d;
      pm_fail_q    <= pm_fail_d;
      idle_q       <= idle_d;
      run_flag_q   <= run_flag_d;
      primary_en_q <= primary_en_d;
      cpu_run_q    <= (state_d != ST_SLEEP) && !idle_d;
      status_q     <= status_d;
      mask_q       <= mask_d;
      irq_q        <= |(status_d & mask_d);
      pm_seen_q    <= pm_seen_q || to_pm;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end
    else
    begin
      ack_q <= acc;
      if (acc)
        dat_q <= rd_dat;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign clk_sel_o    = clk_sel_q;
  assign primary_en_o = primary_en_q;
  assign cpu_run_o    = cpu_run_q;
  assign run_flag_o   = run_flag_q;
  assign irq_o        = irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_fail_state_held: assert property (
    state_q == ST_FAIL && !pm_go |=> state_q == ST_FAIL && clk_sel_q == SRC_INT_RC)
    else $error("failure state left without reset or power-managed entry");

  a_start_on_rc: assert property (
    state_q == ST_START |-> clk_sel_q == SRC_INT_RC && !run_flag_q)
    else $error("device not on internal RC while primary starts");

  a_ready_switch: assert property (
    state_q == ST_START && mon.ready && !mon.fail && !pm_go
    |=> state_q == ST_PRIM && run_flag_q && clk_sel_q == SRC_PRIMARY && status_q[ST_READY_BIT])
    else $error("ready primary not selected or flag not set");

  a_monitor_resumes: assert property (
    state_q == ST_PRIM && cfg_q != CFG_INT_RC |-> mon.mon_en)
    else $error("monitor idle while running on primary");

  a_ctrl_at_reset: assert property (
    state_q == ST_START && !pm_seen_q |-> osc_src_q == SRC_PRIMARY && !run_flag_q)
    else $error("control register moved before power-managed entry");

  a_pm_select: assert property (
    to_pm |=> osc_src_q == $past(pm_src) && clk_sel_q == $past(pm_src))
    else $error("power-managed entry did not select requested source");

  a_pm_fail_rc: assert property (
    state_q == ST_PM && mon.fail && !pm_go |=> clk_sel_q == SRC_INT_RC ##1 (clk_sel_q == SRC_INT_RC || $past(pm_go)))
    else $error("power-managed failure did not fall back to internal RC");

  a_idle_wake: assert property (
    state_q == ST_PM && idle_q && irq_req_i && !pm_go |=> cpu_run_q)
    else $error("interrupt did not end idle");

  a_no_false_fail: assert property (
    state_q == ST_START && mon.need_start |-> !mon.mon_en)
    else $error("crystal start-up watched by the monitor");

  a_pm_stops_primary: assert property (
    state_q == ST_START && to_pm && pm_src != SRC_PRIMARY |=> !primary_en_q)
    else $error("primary still enabled after alternate power-managed entry");

  a_irq_level: assert property (
    |(status_q & mask_q) |-> irq_o)
    else $error("unmasked status without interrupt");
endmodule // cfm_ctrl
`default_nettype wire

// File: design/cfm_fail_det.sv
// Primary clock synchroniser and missing-transition detector
`timescale 1ns/1ps
`default_nettype none
module cfm_fail_det
  import cfm_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic prim_clk_i,
  cfm_mon_if.det    mon
);
  localparam int unsigned CW = $clog2(SAMPLE_CYCLES);
  logic          sync1_q;
  logic          sync2_q;
  logic          last_q;
  logic [CW-1:0] cnt_q;
  logic          seen_q;
  logic          fail_q;
  wire logic     toggled = sync2_q ^ last_q;
  wire logic     tick    = (cnt_q == CW'(SAMPLE_CYCLES - 1));

  always_ff @(posedge clk_i)
  begin
    sync1_q <= prim_clk_i;
    sync2_q <= sync1_q;
    last_q  <= sync2_q;
  end

  // Sample tick stands in for the internal RC sample clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= '0;
      seen_q <= 1'b1;
      fail_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= tick ? '0 : cnt_q + 1'b1;
      // Disarmed monitor counts as seen so enabling it cannot fail at once
      seen_q <= !mon.mon_en || toggled || (seen_q && !tick);
      fail_q <= mon.mon_en && tick && !seen_q && !toggled;
    end
  end

  assign mon.fail      = fail_q;
  assign mon.prim_rise = sync2_q && !last_q;

  a_fail_window: assert property (@(posedge clk_i) disable iff (rst_i)
    mon.mon_en && tick && !seen_q && !toggled |=> mon.fail)
    else $error("missing transition not flagged as failure");
endmodule // cfm_fail_det
`default_nettype wire

// File: design/cfm_mon_if.sv
// Signals between the clock fail controller, its fail detector and start timer
`timescale 1ns/1ps
`default_nettype none
interface cfm_mon_if;
  logic mon_en;
  logic fail;
  logic prim_rise;
  logic tmr_start;
  logic need_start;
  logic need_pll;
  logic ready;
  modport det (input mon_en, output fail, output prim_rise);
  modport tmr (input tmr_start, input need_start, input need_pll, input prim_rise, output ready);
  modport ctl (output mon_en, output tmr_start, output need_start, output need_pll,
               input fail, input ready, input prim_rise);
endinterface
`default_nettype wire

// File: design/cfm_pkg.sv
// Constants and types shared by the clock fail monitor design
package cfm_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SAMPLE_HZ     = 31_250;
  localparam int unsigned SAMPLE_CYC    = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned PLL_LOCK_US   = 2000;
  localparam int unsigned PLL_LOCK_CYC  = PLL_LOCK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OSC_START_CYC = 1024;

  localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFF_PM_CMD   = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_MASK     = 8'h0C;

  localparam int unsigned SRC_LSB      = 0;
  localparam int unsigned RUN_FLAG_BIT = 3;
  localparam int unsigned PM_GO_BIT    = 0;
  localparam int unsigned PM_SRC_LSB   = 1;
  localparam int unsigned PM_MODE_LSB  = 3;
  localparam int unsigned ST_FAIL_BIT  = 0;
  localparam int unsigned ST_READY_BIT = 1;
  localparam logic [1:0]  STATUS_RST   = 2'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  typedef enum logic [1:0] {
    SRC_PRIMARY   = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_INT_RC    = 2'h2
  } cfm_src_t;

  typedef enum logic [1:0] {
    CFG_EXT_CLOCK  = 2'h0,
    CFG_SPEED_XTAL = 2'h1,
    CFG_XTAL_PLL   = 2'h2,
    CFG_INT_RC     = 2'h3
  } cfm_cfg_t;

  typedef enum logic [1:0] {
    PM_RUN   = 2'h0,
    PM_IDLE  = 2'h1,
    PM_SLEEP = 2'h2
  } cfm_pm_t;

  typedef enum logic [4:0] {
    ST_START = 5'h01,
    ST_PRIM  = 5'h02,
    ST_FAIL  = 5'h04,
    ST_PM    = 5'h08,
    ST_SLEEP = 5'h10
  } cfm_state_t;
endpackage

// File: design/cfm_start_tmr.sv
// Oscillator start-up timer followed by the PLL lock timer
`timescale 1ns/1ps
`default_nettype none
module cfm_start_tmr
  import cfm_pkg::*;
#(
  parameter int unsigned START_EDGES = OSC_START_CYC,
  parameter int unsigned PLL_CYCLES  = PLL_LOCK_CYC
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  cfm_mon_if.tmr    mon
);
  localparam int unsigned SW = $clog2(START_EDGES + 1);
  localparam int unsigned PW = $clog2(PLL_CYCLES + 1);
  logic [SW-1:0] osc_cnt_q;
  logic [PW-1:0] pll_cnt_q;
  logic          ready_q;
  wire logic     osc_ok = !mon.need_start || (osc_cnt_q == SW'(START_EDGES));
  wire logic     pll_ok = !mon.need_pll || (pll_cnt_q == PW'(PLL_CYCLES));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || mon.tmr_start)
    begin
      osc_cnt_q <= '0;
      pll_cnt_q <= '0;
      ready_q   <= 1'b0;
    end
    else
    begin
      if (!osc_ok && mon.prim_rise)
        osc_cnt_q <= osc_cnt_q + 1'b1;
      if (osc_ok && !pll_ok)
        pll_cnt_q <= pll_cnt_q + 1'b1;
      ready_q <= osc_ok && pll_ok;
    end
  end

  assign mon.ready = ready_q;
endmodule // cfm_start_tmr
`default_nettype wire
